// [flk_params.svh]
`ifndef FLK_PARAMS_SVH
`define FLK_PARAMS_SVH

// ----------------------------------------
// Command codes (low byte only)
// ----------------------------------------
`define FLK_CMD_READ_ARRAY   8'hff
`define FLK_CMD_READ_STATUS  8'h70
`define FLK_CMD_CLEAR_STATUS 8'h50
`define FLK_CMD_PROGRAM      8'h40
`define FLK_CMD_BLOCK_ERASE  8'h20
`define FLK_CMD_ERASE_ALL    8'ha7
`define FLK_CMD_LOCK_PROGRAM 8'h77
`define FLK_CMD_READ_LOCK    8'h71
`define FLK_CMD_CONFIRM      8'hd0

// ----------------------------------------
// Status byte and mode register fields and reset values
// ----------------------------------------
`define FLK_SR_READY_BIT     7
`define FLK_SR_ERASE_BIT     5
`define FLK_SR_PROG_BIT      4
`define FLK_MRA_READY_BIT    0
`define FLK_MRA_LOCKDIS_BIT  2
`define FLK_MRA_PROG_BIT     6
`define FLK_MRA_ERASE_BIT    7
`define FLK_MRB_LOCK_BIT     6
`define FLK_READY_RESET      1'b1
`define FLK_ERR_RESET        1'b0
`define FLK_LOCK_RESET       1'b1

// ----------------------------------------
// Timing and block counts
// ----------------------------------------
`define FLK_OP_CYCLES        16'h0040
`define FLK_ERASE_ALL_BLOCKS 5'h0d

`endif

// [flk_pkg.sv]
package flk_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    FLK_IDLE,
    FLK_WAIT_CONFIRM,
    FLK_BUSY
  } flk_state_t;

  // Operation being carried out or awaiting its second cycle
  typedef enum logic [2:0] {
    FLK_OP_NONE,
    FLK_OP_PROGRAM,
    FLK_OP_ERASE,
    FLK_OP_ERASE_ALL,
    FLK_OP_LOCK_PROG,
    FLK_OP_READ_LOCK
  } flk_op_t;

endpackage : flk_pkg

// [flk_op_timer.sv]
`timescale 1ns/1ps
`include "flk_params.svh"

module flk_op_timer #(
  parameter int CYCLES = 64
) (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic start_in,
  output logic      done_out
);

  logic [15:0] count;
  logic [15:0] next_count;
  logic        done;
  logic        next_done;

  // Countdown of one array operation, done pulses at the end
  always_comb
  begin
    next_count = count;
    next_done  = 1'b0;
    if (start_in)
    begin
      next_count = 16'(CYCLES);
    end
    else if (count == 16'h0001)
    begin
      next_count = 16'h0000;
      next_done  = 1'b1;
    end
    else if (count != 16'h0000)
    begin
      next_count = count - 16'h0001;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      count <= 16'h0000;
      done  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      done  <= next_done;
    end
  end

  assign done_out = done;

endmodule : flk_op_timer

// [flk_sequencer.sv]
// Function
// - 71h then D0h copies lock bit out
// - One lock bit per block, gated
// - Locked block refuses program and erase
// - Lock cleared by command, set by erase
// - Lock disable unlocks all, bits kept
// - Disabled locks: erase anyway, set bits
// - Ready low during program, erase, lock
// - Status byte ready7 erase5 program4
// - Clear status zeroes both error flags
// - Pending error rejects modifying commands
// - Read status returns status on even-address reads, only while erase_write_mode_zero is set
// - Status readout stays until read array
// - Bad command sets both error flags
// - FFh second cycle cancels to read array, except after 40h
// - Erase error on locked or failed erase
// - Program error on failed program/lock
// - Lock disable suppresses lock errors
// - 77h then D0h clears block lock
// - 50h clears status, upper byte ignored
`timescale 1ns/1ps
`include "flk_params.svh"

module flk_sequencer #(
  parameter int BLOCKS     = 14,
  parameter int BLOCK_W    = 4,
  parameter int ADDR_W     = 20,
  parameter int BLOCK_LSB  = 16,
  parameter int OP_CYCLES  = int'(`FLK_OP_CYCLES)
) (
  input  wire logic                clock_in,
  input  wire logic                rst_in,
  input  wire logic                cmd_write_in,
  input  wire logic [ADDR_W-1:0]   cmd_addr_in,
  input  wire logic [15:0]         cmd_data_in,
  input  wire logic                array_read_in,
  input  wire logic [ADDR_W-1:0]   array_addr_in,
  input  wire logic [15:0]         array_data_in,
  input  wire logic                erase_write_mode_zero,
  input  wire logic                lock_disable_control,
  input  wire logic                verify_fail_in,
  output logic [15:0]              read_data_out,
  output logic                     status_byte_readout,
  output logic [7:0]               flash_sequencer_status,
  output logic [7:0]               flash_mode_reg_a,
  output logic [7:0]               flash_mode_reg_b,
  output logic                     sequencer_ready_flag,
  output logic                     erase_error_flag,
  output logic                     program_error_flag,
  output logic                     lock_status_flag,
  output logic [BLOCKS-1:0]        lock_bits_out
);
  import flk_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [BLOCK_W-1:0] block_of(input logic [ADDR_W-1:0] a);
    block_of = a[BLOCK_LSB +: BLOCK_W];
  endfunction : block_of

  function automatic logic effective_lock(input logic bit_val, input logic disable_val);
    effective_lock = ~bit_val & ~disable_val;
  endfunction : effective_lock

  // ----------------------------------------
  // State
  // ----------------------------------------
  flk_state_t            state;
  flk_state_t            next_state;
  flk_op_t               op;
  flk_op_t               next_op;
  logic [BLOCK_W-1:0]    blk;
  logic [BLOCK_W-1:0]    next_blk;
  logic [BLOCKS-1:0]     locks;
  logic [BLOCKS-1:0]     next_locks;
  logic                  ready;
  logic                  next_ready;
  logic                  err_erase;
  logic                  next_err_erase;
  logic                  err_prog;
  logic                  next_err_prog;
  logic                  lock_flag;
  logic                  next_lock_flag;
  logic                  show_status;
  logic                  next_show_status;
  logic                  fail_seen;
  logic                  next_fail_seen;
  logic                  start_op;
  logic                  op_done;
  logic [15:0]           rdata;
  logic [15:0]           next_rdata;
  logic [7:0]            cmd;
  logic                  err_pend;

  assign cmd      = cmd_data_in[7:0];
  assign err_pend = err_erase | err_prog;

  // Array operation timing
  flk_op_timer #(
    .CYCLES   (OP_CYCLES)
  ) u_timer (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .start_in (start_op),
    .done_out (op_done)
  );

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  // Next state, flags and lock bits
  always_comb
  begin
    next_state       = state;
    next_op          = op;
    next_blk         = blk;
    next_locks       = locks;
    next_ready       = ready;
    next_err_erase   = err_erase;
    next_err_prog    = err_prog;
    next_lock_flag   = lock_flag;
    next_show_status = show_status;
    next_fail_seen   = fail_seen;
    start_op         = 1'b0;
    unique case (state)
      FLK_IDLE:
      begin
        if (cmd_write_in)
        begin
          unique case (cmd)
            `FLK_CMD_READ_ARRAY:
            begin
              next_show_status = 1'b0;
            end
            `FLK_CMD_READ_STATUS:
            begin
              next_show_status = 1'b1;
            end
            `FLK_CMD_CLEAR_STATUS:
            begin
              next_err_erase = 1'b0;
              next_err_prog  = 1'b0;
            end
            `FLK_CMD_PROGRAM, `FLK_CMD_BLOCK_ERASE, `FLK_CMD_ERASE_ALL, `FLK_CMD_LOCK_PROGRAM:
            begin
              if (!err_pend)
              begin
                next_state = FLK_WAIT_CONFIRM;
                next_op    = (cmd == `FLK_CMD_PROGRAM)     ? FLK_OP_PROGRAM :
                             (cmd == `FLK_CMD_BLOCK_ERASE) ? FLK_OP_ERASE :
                             (cmd == `FLK_CMD_ERASE_ALL)   ? FLK_OP_ERASE_ALL : FLK_OP_LOCK_PROG;
              end
            end
            `FLK_CMD_READ_LOCK:
            begin
              next_state = FLK_WAIT_CONFIRM;
              next_op    = FLK_OP_READ_LOCK;
            end
            default:
            begin
              next_err_erase = 1'b1;
              next_err_prog  = 1'b1;
            end
          endcase
        end
      end
      FLK_WAIT_CONFIRM:
      begin
        if (cmd_write_in)
        begin
          next_blk = block_of(cmd_addr_in);
          if (op == FLK_OP_PROGRAM)
          begin
            if (effective_lock(locks[block_of(cmd_addr_in)], lock_disable_control))
            begin
              next_state = FLK_IDLE;
              next_op    = FLK_OP_NONE;
              next_err_prog = 1'b1;
            end
            else
            begin
              next_state = FLK_BUSY;
              next_ready = 1'b0;
              start_op   = 1'b1;
              next_show_status = erase_write_mode_zero ? 1'b1 : show_status;
            end
          end
          else if (cmd == `FLK_CMD_READ_ARRAY)
          begin
            next_state       = FLK_IDLE;
            next_op          = FLK_OP_NONE;
            next_show_status = 1'b0;
          end
          else if (cmd != `FLK_CMD_CONFIRM)
          begin
            next_state     = FLK_IDLE;
            next_op        = FLK_OP_NONE;
            next_err_erase = 1'b1;
            next_err_prog  = 1'b1;
          end
          else if (op == FLK_OP_ERASE &&
                   effective_lock(locks[block_of(cmd_addr_in)], lock_disable_control))
          begin
            next_state     = FLK_IDLE;
            next_op        = FLK_OP_NONE;
            next_err_erase = 1'b1;
          end
          else
          begin
            next_state = FLK_BUSY;
            next_ready = 1'b0;
            start_op   = 1'b1;
            if (op != FLK_OP_READ_LOCK && erase_write_mode_zero)
            begin
              next_show_status = 1'b1;
            end
          end
          next_fail_seen = 1'b0;
        end
      end
      FLK_BUSY:
      begin
        next_fail_seen = fail_seen | verify_fail_in;
        if (op_done)
        begin
          next_state = FLK_IDLE;
          next_op    = FLK_OP_NONE;
          next_ready = 1'b1;
          unique case (op)
            FLK_OP_READ_LOCK:
            begin
              next_lock_flag = locks[blk];
            end
            FLK_OP_LOCK_PROG:
            begin
              if (fail_seen)
              begin
                next_err_prog = 1'b1;
              end
              else
              begin
                next_locks[blk] = 1'b0;
              end
            end
            FLK_OP_ERASE:
            begin
              if (fail_seen)
              begin
                next_err_erase = 1'b1;
              end
              else
              begin
                next_locks[blk] = 1'b1;
              end
            end
            FLK_OP_ERASE_ALL:
            begin
              if (fail_seen)
              begin
                next_err_erase = 1'b1;
              end
              for (int i = 0; i < BLOCKS; i++)
              begin
                if (i < int'(`FLK_ERASE_ALL_BLOCKS) && !fail_seen &&
                    (lock_disable_control || locks[i]))
                begin
                  next_locks[i] = 1'b1;
                end
              end
            end
            FLK_OP_PROGRAM:
            begin
              if (fail_seen)
              begin
                next_err_prog = 1'b1;
              end
            end
            default:
            begin
              next_op = FLK_OP_NONE;
            end
          endcase
        end
      end
      default:
      begin
        next_state = FLK_IDLE;
      end
    endcase
  end

  // Read data path: status byte or array word
  always_comb
  begin
    next_rdata = rdata;
    if (array_read_in)
    begin
      if (erase_write_mode_zero && show_status && !array_addr_in[0])
      begin
        next_rdata = {8'h00, flash_sequencer_status};
      end
      else
      begin
        next_rdata = array_data_in;
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state       <= FLK_IDLE;
      op          <= FLK_OP_NONE;
      blk         <= '0;
      locks       <= {BLOCKS{`FLK_LOCK_RESET}};
      ready       <= `FLK_READY_RESET;
      err_erase   <= `FLK_ERR_RESET;
      err_prog    <= `FLK_ERR_RESET;
      lock_flag   <= 1'b0;
      show_status <= 1'b0;
      fail_seen   <= 1'b0;
      rdata       <= 16'h0000;
    end
    else
    begin
      state       <= next_state;
      op          <= next_op;
      blk         <= next_blk;
      locks       <= next_locks;
      ready       <= next_ready;
      err_erase   <= next_err_erase;
      err_prog    <= next_err_prog;
      lock_flag   <= next_lock_flag;
      show_status <= next_show_status;
      fail_seen   <= next_fail_seen;
      rdata       <= next_rdata;
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  // Status byte and its mirrors
  always_comb
  begin
    flash_sequencer_status = 8'h00;
    flash_sequencer_status[`FLK_SR_READY_BIT] = ready;
    flash_sequencer_status[`FLK_SR_ERASE_BIT] = err_erase;
    flash_sequencer_status[`FLK_SR_PROG_BIT]  = err_prog;
    flash_mode_reg_a       = 8'h00;
    flash_mode_reg_a[`FLK_MRA_READY_BIT]   = ready;
    flash_mode_reg_a[`FLK_MRA_LOCKDIS_BIT] = lock_disable_control;
    flash_mode_reg_a[`FLK_MRA_PROG_BIT]    = err_prog;
    flash_mode_reg_a[`FLK_MRA_ERASE_BIT]   = err_erase;
    flash_mode_reg_b       = 8'h00;
    flash_mode_reg_b[`FLK_MRB_LOCK_BIT]    = lock_flag;
  end

  assign read_data_out        = rdata;
  assign status_byte_readout  = show_status;
  assign sequencer_ready_flag = ready;
  assign erase_error_flag     = err_erase;
  assign program_error_flag   = err_prog;
  assign lock_status_flag     = lock_flag;
  assign lock_bits_out        = locks;

endmodule : flk_sequencer

// [flk_sequencer_sva.sv]
`timescale 1ns/1ps
module flk_sequencer_chk #(
  parameter int BLOCKS = 14,
  parameter int ADDR_W = 20
) (
  input wire logic              clock_in,
  input wire logic              rst_in,
  input wire logic              cmd_write_in,
  input wire logic [15:0]       cmd_data_in,
  input wire logic              array_read_in,
  input wire logic [ADDR_W-1:0] array_addr_in,
  input wire logic [15:0]       array_data_in,
  input wire logic              erase_write_mode_zero,
  input wire logic              lock_disable_control,
  input wire logic [15:0]       read_data_out,
  input wire logic              status_byte_readout,
  input wire logic [7:0]        flash_sequencer_status,
  input wire logic [7:0]        flash_mode_reg_a,
  input wire logic [7:0]        flash_mode_reg_b,
  input wire logic              sequencer_ready_flag,
  input wire logic              erase_error_flag,
  input wire logic              program_error_flag,
  input wire logic              lock_status_flag,
  input wire logic [BLOCKS-1:0] lock_bits_out
);
  // ------
  // Checks
  // ------
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  status_map_a: assert property (flash_sequencer_status == {sequencer_ready_flag, 1'b0,
    erase_error_flag, program_error_flag, 4'h0}) else $error("status byte layout wrong");
  mode_mirror_a: assert property (flash_mode_reg_a[0] == sequencer_ready_flag
    && flash_mode_reg_a[7:6] == {erase_error_flag, program_error_flag}) else $error("mode mirror wrong");
  lock_mirror_a: assert property (flash_mode_reg_b[6] == lock_status_flag)
    else $error("lock flag mirror wrong");
  busy_min_a: assert property ($fell(sequencer_ready_flag) |-> !sequencer_ready_flag [*4])
    else $error("busy too short");
  busy_cause_a: assert property ($fell(sequencer_ready_flag) |-> $past(cmd_write_in))
    else $error("busy without command");
  clear_cause_a: assert property ($fell(erase_error_flag) || $fell(program_error_flag)
    |-> $past(cmd_write_in && cmd_data_in[7:0] == 8'h50)) else $error("error cleared without clear");
  err_cause_a: assert property ($rose(erase_error_flag) || $rose(program_error_flag)
    |-> $past(cmd_write_in) || $past(!sequencer_ready_flag) || $past(!sequencer_ready_flag, 2))
    else $error("error raised without cause");
  stat_read_a: assert property (array_read_in && status_byte_readout && erase_write_mode_zero
    && !array_addr_in[0] |=> read_data_out == {8'h00, $past(flash_sequencer_status)})
    else $error("status read wrong");
  array_read_a: assert property (array_read_in
    && !(status_byte_readout && erase_write_mode_zero && !array_addr_in[0])
    |=> read_data_out == $past(array_data_in)) else $error("array read wrong");
  lock_keep_a: assert property ($changed(lock_disable_control) |-> $stable(lock_bits_out))
    else $error("lock bits moved with disable");
endmodule : flk_sequencer_chk

bind flk_sequencer flk_sequencer_chk #(.BLOCKS(BLOCKS), .ADDR_W(ADDR_W)) u_chk (.clock_in, .rst_in,
  .cmd_write_in, .cmd_data_in, .array_read_in, .array_addr_in, .array_data_in, .erase_write_mode_zero,
  .lock_disable_control,
  .read_data_out, .status_byte_readout, .flash_sequencer_status, .flash_mode_reg_a, .flash_mode_reg_b,
  .sequencer_ready_flag, .erase_error_flag, .program_error_flag, .lock_status_flag, .lock_bits_out);

// [flk_cpu_model.sv]
`timescale 1ns/1ps
module flk_cpu_model #(
  parameter int ADDR_W = 20
) (
  input  wire logic              clock_in,
  input  wire logic [15:0]       read_data_in,
  output logic                   cmd_write_out,
  output logic [ADDR_W-1:0]      cmd_addr_out,
  output logic [15:0]            cmd_data_out,
  output logic                   array_read_out,
  output logic [ADDR_W-1:0]      array_addr_out
);
  // Idle bus at time zero
  initial
  begin
    cmd_write_out = 1'b0;
    cmd_addr_out = '0;
    cmd_data_out = 16'h0000;
    array_read_out = 1'b0;
    array_addr_out = '0;
  end

  // One bus write, lines scrambled once released
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(negedge clock_in);
    cmd_write_out = 1'b1;
    cmd_addr_out = a;
    cmd_data_out = d;
    @(negedge clock_in);
    cmd_write_out = 1'b0;
    cmd_addr_out = ~a;
    cmd_data_out = ~d;
  endtask : wr

  // One read, data taken the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] q);
    @(negedge clock_in);
    array_read_out = 1'b1;
    array_addr_out = a;
    @(negedge clock_in);
    array_read_out = 1'b0;
    array_addr_out = ~a;
    q = read_data_in;
  endtask : rd
endmodule : flk_cpu_model

// [flash_lock_and_status_sequencer_test.sv]
`timescale 1ns/1ps
module flash_lock_and_status_sequencer_test;
  logic        clock_in;
  logic        rst_in;
  logic        cmd_write, array_read, ewm0, lock_dis, vfail;
  logic [19:0] cmd_addr, array_addr;
  logic [15:0] cmd_data, read_data, q;
  logic [15:0] array_data = 16'hc3a5;
  logic [7:0]  status, mode_a, mode_b;
  logic        readout, ready, erase_err, prog_err, lock_flag;
  logic [13:0] lock_bits;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;

  // ------
  // Clock, design and host
  // ------
  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  flk_sequencer #(.OP_CYCLES(4)) uut (.clock_in(clock_in), .rst_in(rst_in), .cmd_write_in(cmd_write),
    .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data), .array_read_in(array_read), .array_addr_in(array_addr),
    .array_data_in(array_data), .erase_write_mode_zero(ewm0), .lock_disable_control(lock_dis),
    .verify_fail_in(vfail), .read_data_out(read_data), .status_byte_readout(readout),
    .flash_sequencer_status(status), .flash_mode_reg_a(mode_a), .flash_mode_reg_b(mode_b),
    .sequencer_ready_flag(ready), .erase_error_flag(erase_err), .program_error_flag(prog_err),
    .lock_status_flag(lock_flag), .lock_bits_out(lock_bits));

  flk_cpu_model u_cpu (.clock_in(clock_in), .read_data_in(read_data), .cmd_write_out(cmd_write),
    .cmd_addr_out(cmd_addr), .cmd_data_out(cmd_data), .array_read_out(array_read),
    .array_addr_out(array_addr));

  // ------
  // Helpers
  // ------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [19:0] ba(input logic [3:0] b);
    return {b, 16'hfffe};
  endfunction : ba

  // Two-cycle command, then wait for ready
  task automatic cmd2(input logic [7:0] c, input logic [3:0] b, input logic [15:0] d, input logic busy);
    u_cpu.wr(ba(b), {8'ha5, c});
    u_cpu.wr(ba(b), d);
    @(negedge clock_in);
    chk(ready, !busy);
    repeat (100) if (!ready) @(negedge clock_in);
  endtask : cmd2

  task automatic clr;
    u_cpu.wr(ba(0), 16'hab50);
    @(negedge clock_in);
  endtask : clr

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // ------
  // Scenarios
  // ------
  task automatic s_reset;
    chk(status, 16'h0080);
    chk(lock_bits, 16'h3fff);
  endtask : s_reset

  task automatic s_lock;
    cmd2(8'h77, 3, 16'h00d0, 1);
    chk(lock_bits, 16'h3ff7);
    cmd2(8'h71, 2, 16'h00d0, 1);
    chk(lock_flag, 1);
    chk(mode_b, 16'h0040);
    cmd2(8'h71, 3, 16'h00d0, 1);
    chk(lock_flag, 0);
  endtask : s_lock

  task automatic s_protect;
    cmd2(8'h20, 3, 16'h00d0, 0);
    chk({erase_err, prog_err}, 2'b10);
    clr;
    chk({erase_err, prog_err}, 2'b00);
    cmd2(8'h40, 3, 16'h1234, 0);
    chk({erase_err, prog_err}, 2'b01);
    cmd2(8'h77, 2, 16'h00d0, 0);
    chk(lock_bits, 16'h3ff7);
    clr;
  endtask : s_protect

  task automatic s_disable;
    cmd2(8'h77, 13, 16'h00d0, 1);
    @(negedge clock_in);
    lock_dis = 1'b1;
    cmd2(8'h40, 3, 16'h1234, 1);
    chk({erase_err, prog_err}, 2'b00);
    chk(mode_a, 16'h0005);
    chk(lock_bits, 16'h1ff7);
    cmd2(8'hA7, 0, 16'h00d0, 1);
    chk(lock_bits, 16'h1fff);
    cmd2(8'h20, 13, 16'h00d0, 1);
    chk(lock_bits, 16'h3fff);
    @(negedge clock_in);
    lock_dis = 1'b0;
  endtask : s_disable

  task automatic s_seq;
    u_cpu.wr(ba(2), 16'h0020);
    u_cpu.wr(ba(2), 16'h0012);
    @(negedge clock_in);
    chk({erase_err, prog_err}, 2'b11);
    clr;
    u_cpu.wr(ba(2), 16'h0033);
    @(negedge clock_in);
    chk({erase_err, prog_err}, 2'b11);
    clr;
    u_cpu.wr(ba(2), 16'h0070);
    u_cpu.wr(ba(2), 16'h0020);
    u_cpu.wr(ba(2), 16'h00ff);
    @(negedge clock_in);
    chk({erase_err, prog_err, readout, ready}, 4'b0001);
  endtask : s_seq

  task automatic s_readout;
    ewm0 = 1'b1;
    u_cpu.wr(ba(0), 16'h0070);
    u_cpu.rd(ba(0), q);
    chk(q, 16'h0080);
    u_cpu.wr(ba(0), 16'h00ff);
    u_cpu.rd(ba(0), q);
    chk(q, array_data);
    vfail = 1'b1;
    cmd2(8'h40, 2, 16'h5555, 1);
    vfail = 1'b0;
    u_cpu.rd(ba(4), q);
    chk(q, 16'h0090);
    chk(mode_a, 16'h0041);
    clr;
    ewm0 = 1'b0;
  endtask : s_readout

  // Cycle ceiling against hangs
  always @(posedge clock_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  // Main sequence
  initial
  begin
    rst_in = 1'b1;
    ewm0 = 1'b0;
    lock_dis = 1'b0;
    vfail = 1'b0;
    repeat (20) @(negedge clock_in);
    rst_in = 1'b0;
    s_reset();
    s_lock();
    s_protect();
    s_disable();
    s_seq();
    s_readout();
    end_of_test();
  end
endmodule : flash_lock_and_status_sequencer_test
